// [pcsi_core.sv]
// Program counter sequencing, paging, return stack use and indirect data addressing
module pcsi_core
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic clock_en,
	input wire logic fetch,
	input wire logic [2:0] seq_op,
	input wire logic [pcsi_pkg::JMP_W-1:0] jump_target,
	input wire logic pcl_write,
	input wire logic [pcsi_pkg::LOW_W-1:0] pcl_wdata,
	input wire logic [pcsi_pkg::PC_W-1:0] intr_vector,
	input wire logic latch_write,
	input wire logic [pcsi_pkg::HIGH_W-1:0] latch_wdata,
	input wire logic fsr_write,
	input wire logic [pcsi_pkg::LOW_W-1:0] fsr_wdata,
	input wire logic bank_pointer_bit,
	input wire logic [pcsi_pkg::FILE_W-1:0] file_addr,
	input wire logic file_read,
	input wire logic file_write,
	input wire logic [pcsi_pkg::LOW_W-1:0] file_wdata,
	input wire logic [pcsi_pkg::LOW_W-1:0] mem_rdata,
	output logic [pcsi_pkg::PC_W-1:0] program_counter,
	output logic [pcsi_pkg::LOW_W-1:0] program_counter_low,
	output logic [pcsi_pkg::HIGH_W-1:0] pc_high_latch,
	output logic [pcsi_pkg::LOW_W-1:0] file_pointer,
	output logic [pcsi_pkg::DADDR_W-1:0] mem_addr,
	output logic mem_read,
	output logic mem_write,
	output logic [pcsi_pkg::LOW_W-1:0] mem_wdata,
	output logic indirect_null_read
);
	import pcsi_pkg::*;

	logic [PC_W-1:0] pc_r;
	logic [PC_W-1:0] pc_nxt;
	logic [HIGH_W-1:0] latch_r;
	logic [LOW_W-1:0] fsr_r;
	logic [DADDR_W-1:0] maddr_r;
	logic mrd_r;
	logic mwr_r;
	logic [LOW_W-1:0] mwdata_r;
	logic null_r;
	logic [PC_W-1:0] stack_top;
	logic [PC_W-1:0] pc_inc;
	logic [PC_W-1:0] pc_jump;
	logic [PC_W-1:0] pc_pcl;
	logic do_push;
	logic do_pop;
	logic is_indirect;
	logic self_indirect;
	logic [LOW_W-1:0] eff_fsr;
	logic [DADDR_W-1:0] ind_addr;
	logic [DADDR_W-1:0] dir_addr;
	pcsi_seq_e op;

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function automatic logic is_port(input logic [FILE_W-1:0] a);
		is_port = (a == INDIRECT_PORT_ADDR);
	endfunction : is_port

	assign op = pcsi_seq_e'(seq_op);
	assign pc_inc = pc_r + PC_ONE;
	assign pc_jump = {latch_r[PAGE_HI:PAGE_LO], jump_target};
	assign pc_pcl = {latch_r, pcl_wdata};
	assign do_push = fetch && (op == PCSI_SEQ_CALL || op == PCSI_SEQ_INTR);
	assign do_pop = fetch && op == PCSI_SEQ_RETURN;

	// ----------------------------------------
	// Program counter next value
	// ----------------------------------------
	always_comb
	begin
		pc_nxt = pc_r;
		if (fetch)
		begin
			case (op)
				PCSI_SEQ_NEXT: pc_nxt = pcl_write ? pc_pcl : pc_inc;
				PCSI_SEQ_JUMP: pc_nxt = pc_jump;
				PCSI_SEQ_CALL: pc_nxt = pc_jump;
				PCSI_SEQ_RETURN: pc_nxt = stack_top;
				PCSI_SEQ_INTR: pc_nxt = intr_vector;
				PCSI_SEQ_HOLD: pc_nxt = pc_r;
				default: pc_nxt = pc_r;
			endcase
		end
		else if (pcl_write)
			pc_nxt = pc_pcl;
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			pc_r <= PC_RESET;
		else if (clock_en)
			pc_r <= pc_nxt;
	end

	// ----------------------------------------
	// High latch, unaffected by stack traffic
	// ----------------------------------------
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			latch_r <= '0;
		else if (clock_en && latch_write)
			latch_r <= latch_wdata;
	end

	// ----------------------------------------
	// Return stack
	// ----------------------------------------
	pcsi_stack u_stack
	(
		.clock(clock),
		.reset_n(reset_n),
		.enable(clock_en),
		.push(do_push),
		.pop(do_pop),
		.push_data(pc_inc),
		.top_data(stack_top)
	);

	// ----------------------------------------
	// Indirect addressing
	// ----------------------------------------
	assign is_indirect = is_port(file_addr);
	assign eff_fsr = fsr_r;
	assign self_indirect = is_indirect && is_port(eff_fsr[FILE_W-1:0]);
	assign ind_addr = {bank_pointer_bit, eff_fsr};
	assign dir_addr = {bank_pointer_bit, 1'b0, file_addr};

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			fsr_r <= BYTE_ZERO;
		else if (clock_en && fsr_write)
			fsr_r <= fsr_wdata;
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			maddr_r <= '0;
			mrd_r <= 1'b0;
			mwr_r <= 1'b0;
			mwdata_r <= BYTE_ZERO;
			null_r <= 1'b0;
		end
		else if (clock_en)
		begin
			maddr_r <= is_indirect ? ind_addr : dir_addr;
			mrd_r <= file_read && !self_indirect;
			mwr_r <= file_write && !self_indirect;
			mwdata_r <= file_wdata;
			null_r <= file_read && self_indirect;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign program_counter = pc_r;
	assign program_counter_low = pc_r[LOW_W-1:0];
	assign pc_high_latch = latch_r;
	assign file_pointer = fsr_r;
	assign mem_addr = maddr_r;
	assign mem_read = mrd_r;
	assign mem_write = mwr_r;
	assign mem_wdata = mwdata_r;
	assign indirect_null_read = null_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_pc_increment: assert property (@(posedge clock) disable iff (!reset_n)
		clock_en && fetch && op == PCSI_SEQ_NEXT && !pcl_write
		|=> pc_r == $past(pc_r) + PC_ONE)
		else $error("Counter did not increment");
	a_pcl_load: assert property (@(posedge clock) disable iff (!reset_n)
		clock_en && pcl_write && !fetch |=> pc_r == {$past(latch_r), $past(pcl_wdata)})
		else $error("Low byte write did not load full counter");
	a_jump_page: assert property (@(posedge clock) disable iff (!reset_n)
		clock_en && fetch && op == PCSI_SEQ_JUMP
		|=> pc_r == {$past(latch_r[PAGE_HI:PAGE_LO]), $past(jump_target)})
		else $error("Jump target paged wrongly");
	a_call_return: assert property (@(posedge clock) disable iff (!reset_n)
		clock_en && fetch && op == PCSI_SEQ_CALL ##1
		clock_en && fetch && op == PCSI_SEQ_RETURN |=> pc_r == $past(pc_r, 2) + PC_ONE)
		else $error("Return did not restore call address");
	a_latch_stable: assert property (@(posedge clock) disable iff (!reset_n)
		(do_push || do_pop) && !latch_write |=> $stable(latch_r))
		else $error("Latch changed on stack operation");
	a_ind_addr: assert property (@(posedge clock) disable iff (!reset_n)
		clock_en && is_indirect |=> mem_addr == {$past(bank_pointer_bit), $past(fsr_r)})
		else $error("Indirect address formed wrongly");
	a_self_write: assert property (@(posedge clock) disable iff (!reset_n)
		clock_en && self_indirect |=> !mem_write && !mem_read)
		else $error("Self indirect access reached memory");
	a_self_read: assert property (@(posedge clock) disable iff (!reset_n)
		clock_en && self_indirect && file_read |=> indirect_null_read)
		else $error("Self indirect read not flagged as zero");
endmodule : pcsi_core

// [pcsi_pkg.sv]
// Package of constants and types for the program counter, return stack and indirect addressing
// Notes on behaviour
// - Program counter is 13 bits; its low byte reads and writes as a register.
// - Upper five counter bits change on carry, jump, call, return and interrupt, or by transfer from the high latch.
// - Every reset clears the whole program counter to zero.
// - Writing the low byte loads upper bits from the high latch together.
// - Call and jump take 11 instruction bits plus latch bits 4 and 3.
// - Call or interrupt branch pushes the full 13-bit return address.
// - Return stack is eight deep, 13 wide, with a hidden pointer.
// - Return pops the stack top into the counter.
// - Push and pop leave the high latch untouched.
// - Stack is circular; a ninth push overwrites the oldest entry.
// - No overflow or underflow flags; extra pops return stored entries.
// - Accessing the indirect port accesses memory at the file pointer.
// - Indirect port reached indirectly reads zero and writes nothing.
// - Indirect address is 9 bits: bank bit joined with 8-bit pointer.
package pcsi_pkg;
	localparam int PC_W = 13;
	localparam int LOW_W = 8;
	localparam int HIGH_W = 5;
	localparam int JMP_W = 11;
	localparam int PAGE_LO = 3;
	localparam int PAGE_HI = 4;
	localparam int DEPTH = 8;
	localparam int SP_W = 3;
	localparam int DADDR_W = 9;
	localparam int FILE_W = 7;
	localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
	localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
	localparam logic [SP_W-1:0] SP_RESET = 3'h0;
	localparam logic [SP_W-1:0] SP_ONE = 3'h1;
	localparam logic [LOW_W-1:0] BYTE_ZERO = 8'h00;
	localparam logic [FILE_W-1:0] INDIRECT_PORT_ADDR = 7'h00;
	localparam logic [FILE_W-1:0] PCL_ADDR = 7'h02;

	typedef enum logic [2:0]
	{
		PCSI_SEQ_NEXT,
		PCSI_SEQ_JUMP,
		PCSI_SEQ_CALL,
		PCSI_SEQ_RETURN,
		PCSI_SEQ_INTR,
		PCSI_SEQ_HOLD
	} pcsi_seq_e;
endpackage : pcsi_pkg

// [pcsi_stack.sv]
// Circular eight-entry return stack with hidden pointer
module pcsi_stack
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic enable,
	input wire logic push,
	input wire logic pop,
	input wire logic [pcsi_pkg::PC_W-1:0] push_data,
	output logic [pcsi_pkg::PC_W-1:0] top_data
);
	import pcsi_pkg::*;

	logic [PC_W-1:0] entry_r [DEPTH];
	logic [SP_W-1:0] sp_r;
	logic [SP_W-1:0] sp_nxt;
	logic [SP_W-1:0] sp_prev;

	// ----------------------------------------
	// Pointer arithmetic
	// ----------------------------------------
	assign sp_prev = sp_r - SP_ONE;
	assign sp_nxt = push ? sp_r + SP_ONE : (pop ? sp_prev : sp_r);
	assign top_data = entry_r[sp_prev];

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			sp_r <= SP_RESET;
		else if (enable)
			sp_r <= sp_nxt;
	end

	// ----------------------------------------
	// Entry storage
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++)
		begin : g_entry
			always_ff @(posedge clock or negedge reset_n)
			begin
				if (!reset_n)
					entry_r[gi] <= PC_RESET;
				else if (enable && push && sp_r == SP_W'(gi))
					entry_r[gi] <= push_data;
			end
		end
	endgenerate

	a_wrap_pointer: assert property (@(posedge clock) disable iff (!reset_n)
		enable && push && !pop |=> sp_r == $past(sp_r) + SP_ONE)
		else $error("Stack pointer did not advance on push");
endmodule : pcsi_stack

// [pcsi_mem_model.sv]
// Data memory model that answers the indirect and direct accesses of the core
module pcsi_mem_model import pcsi_pkg::*;
(
	input wire logic clock,
	input wire logic [pcsi_pkg::DADDR_W-1:0] mem_addr,
	input wire logic mem_read,
	input wire logic mem_write,
	input wire logic [pcsi_pkg::LOW_W-1:0] mem_wdata,
	output logic [pcsi_pkg::LOW_W-1:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [LOW_W-1:0] store [0:(1<<DADDR_W)-1];
	logic [LOW_W-1:0] idle_r;
	// ----------------------------------------
	// Storage and read data
	// ----------------------------------------
	initial
	begin
		idle_r = 8'h5A;
		for (int i = 0; i < (1 << DADDR_W); i++)
			store[i] = 8'h00;
	end
	always @(posedge clock)
	begin
		if (mem_write)
			store[mem_addr] <= mem_wdata;
		idle_r <= ~idle_r;
	end
	// Idle read lines toggle so a stale value never looks valid
	assign mem_rdata = mem_read ? store[mem_addr] : idle_r;
endmodule : pcsi_mem_model

// [pcsi_core_test.sv]
// Testbench for the program counter, return stack and indirect addressing core
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin miscompares++; \
	$display("Error at %0t ns: got %h expected %h", $time, got, exp); end end
module pcsi_core_test import pcsi_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock, reset_n, clock_en, fetch, pcl_write, latch_write, fsr_write;
	logic bank_pointer_bit, file_read, file_write, mem_read, mem_write, indirect_null_read;
	logic [2:0] seq_op;
	logic [JMP_W-1:0] jump_target;
	logic [LOW_W-1:0] pcl_wdata, fsr_wdata, file_wdata, mem_rdata, program_counter_low;
	logic [LOW_W-1:0] file_pointer, mem_wdata;
	logic [PC_W-1:0] intr_vector, program_counter, exp_pc;
	logic [PC_W-1:0] ret [0:8];
	logic [HIGH_W-1:0] latch_wdata, pc_high_latch;
	logic [FILE_W-1:0] file_addr;
	logic [DADDR_W-1:0] mem_addr;
	int miscompares, compares;
	// ----------------------------------------
	// Design and partner
	// ----------------------------------------
	pcsi_core pcsi_core_i
	(
		.clock(clock), .reset_n(reset_n), .clock_en(clock_en), .fetch(fetch),
		.seq_op(seq_op), .jump_target(jump_target), .pcl_write(pcl_write),
		.pcl_wdata(pcl_wdata), .intr_vector(intr_vector), .latch_write(latch_write),
		.latch_wdata(latch_wdata), .fsr_write(fsr_write), .fsr_wdata(fsr_wdata),
		.bank_pointer_bit(bank_pointer_bit), .file_addr(file_addr), .file_read(file_read),
		.file_write(file_write), .file_wdata(file_wdata), .mem_rdata(mem_rdata),
		.program_counter(program_counter), .program_counter_low(program_counter_low),
		.pc_high_latch(pc_high_latch), .file_pointer(file_pointer), .mem_addr(mem_addr),
		.mem_read(mem_read), .mem_write(mem_write), .mem_wdata(mem_wdata),
		.indirect_null_read(indirect_null_read)
	);
	pcsi_mem_model pcsi_mem_model_i
	(
		.clock(clock), .mem_addr(mem_addr), .mem_read(mem_read), .mem_write(mem_write),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata)
	);
	always #5 clock = ~clock;
	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task automatic end_sim;
		if (miscompares == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim
	task automatic tick;
		@(negedge clock);
		{fetch, pcl_write, latch_write, fsr_write, file_read, file_write} = 6'h00;
	endtask : tick
	task automatic run(input pcsi_seq_e s, input logic [JMP_W-1:0] t);
		fetch = 1'b1;
		seq_op = s;
		jump_target = t;
		tick;
	endtask : run
	task automatic set_latch(input logic [HIGH_W-1:0] v);
		latch_write = 1'b1;
		latch_wdata = v;
		tick;
	endtask : set_latch
	task automatic set_pcl(input logic [LOW_W-1:0] v);
		pcl_write = 1'b1;
		pcl_wdata = v;
		tick;
	endtask : set_pcl
	task automatic set_fsr(input logic [LOW_W-1:0] v);
		fsr_write = 1'b1;
		fsr_wdata = v;
		tick;
	endtask : set_fsr
	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial
	begin
		{clock, reset_n, fetch, pcl_write, latch_write, fsr_write, file_read, file_write} = 8'h00;
		{seq_op, jump_target, pcl_wdata, latch_wdata, fsr_wdata, file_addr, file_wdata} = '0;
		{bank_pointer_bit, clock_en, intr_vector} = {2'h3, 13'h0004};
		repeat (16) @(negedge clock);
		reset_n = 1'b1;
		tick;
		`CHK(program_counter, PC_RESET)
		for (int i = 0; i < 3; i++)
			run(PCSI_SEQ_NEXT, 11'h000);
		`CHK(program_counter, 13'h0003)
		set_latch(5'h13);
		`CHK(program_counter, 13'h0003)
		set_pcl(8'hFF);
		`CHK(program_counter, 13'h13FF)
		`CHK(program_counter_low, 8'hFF)
		run(PCSI_SEQ_NEXT, 11'h000);
		`CHK(program_counter, 13'h1400)
		set_latch(5'h14);
		set_pcl(8'h10);
		`CHK(program_counter, 13'h1410)
		set_latch(5'h1F);
		set_pcl(8'hFF);
		run(PCSI_SEQ_NEXT, 11'h000);
		`CHK(program_counter, 13'h0000)
		set_latch(5'h17);
		run(PCSI_SEQ_JUMP, 11'h2AB);
		`CHK(program_counter, 13'h12AB)
		exp_pc = 13'h12AB;
		for (int i = 0; i < 9; i++)
		begin
			ret[i] = exp_pc + 13'h0001;
			run(PCSI_SEQ_CALL, 11'h100 + 11'(i));
			exp_pc = {2'b10, 11'h100 + 11'(i)};
			`CHK(program_counter, exp_pc)
		end
		`CHK(pc_high_latch, 5'h17)
		for (int i = 0; i < 9; i++)
		begin
			run(PCSI_SEQ_RETURN, 11'h000);
			`CHK(program_counter, ret[(i == 8) ? 8 : 8 - i])
		end
		`CHK(pc_high_latch, 5'h17)
		run(PCSI_SEQ_INTR, 11'h000);
		`CHK(program_counter, 13'h0004)
		run(PCSI_SEQ_RETURN, 11'h000);
		`CHK(program_counter, ret[8] + 13'h0001)
		run(PCSI_SEQ_HOLD, 11'h000);
		`CHK(program_counter, ret[8] + 13'h0001)
		set_fsr(8'h55);
		`CHK(file_pointer, 8'h55)
		file_addr = INDIRECT_PORT_ADDR;
		file_read = 1'b1;
		tick;
		`CHK({mem_read, mem_addr}, {1'b1, 9'h155})
		file_write = 1'b1;
		file_wdata = 8'hA5;
		bank_pointer_bit = 1'b0;
		tick;
		`CHK({mem_write, mem_wdata, mem_addr}, {1'b1, 8'hA5, 9'h055})
		set_fsr(8'h00);
		file_read = 1'b1;
		tick;
		`CHK({mem_read, indirect_null_read}, 2'b01)
		file_write = 1'b1;
		tick;
		`CHK(mem_write, 1'b0)
		clock_en = 1'b0;
		run(PCSI_SEQ_NEXT, 11'h000);
		clock_en = 1'b1;
		`CHK(program_counter, ret[8] + 13'h0001)
		reset_n = 1'b0;
		tick;
		`CHK(program_counter, PC_RESET)
		reset_n = 1'b1;
		tick;
		end_sim;
	end
	initial
	begin
		repeat (20000) @(posedge clock);
		miscompares++;
		end_sim;
	end
endmodule : pcsi_core_test
